// ===== verilog/ufc_pkg.sv
// constants and carrier types for the uart flow control and dma block
// assumes a 32-bit apb register bus and 16-entry fifos outside this block
package ufc_pkg;
    // register byte offsets
    localparam logic [11:0] OFF_SERIAL_CTRL = 12'h030;
    localparam logic [11:0] OFF_FIFO_LEVEL = 12'h034;
    localparam logic [11:0] OFF_DMA_CTRL = 12'h048;
    localparam logic [11:0] OFF_FLOW_STATUS = 12'h04C;
    localparam logic [11:0] OFF_FLOW_CONFIG = 12'h050;

    // reset values
    localparam logic [15:0] RST_SERIAL_CTRL = 16'h0300;
    localparam logic [5:0] RST_FIFO_LEVEL = 6'h12;
    localparam logic [2:0] RST_DMA_CTRL = 3'h0;
    localparam logic [1:0] RST_FLOW_CONFIG = 2'h1;

    // serial control register fields
    localparam int CR_UART_EN = 0;
    localparam int CR_TERM_READY = 10;
    localparam int CR_REQ_SEND = 11;
    localparam int CR_SPARE_ONE = 12;
    localparam int CR_SPARE_TWO = 13;
    localparam int CR_RX_FLOW_EN = 14;
    localparam int CR_TX_FLOW_EN = 15;

    // fifo level select fields
    localparam int IFLS_TX_LSB = 0;
    localparam int IFLS_RX_LSB = 3;
    localparam int IFLS_W = 3;

    // dma control fields
    localparam int DMA_RX_EN = 0;
    localparam int DMA_TX_EN = 1;
    localparam int DMA_OFF_ERR = 2;

    // flow config fields
    localparam int CFG_FIFO_EN = 0;
    localparam int CFG_COMM_ROLE = 1;

    // fifo geometry
    localparam int FIFO_DEPTH = 16;
    localparam int LEVEL_W = 5;
    localparam int RX_CHAR_W = 12;
    localparam int TX_CHAR_W = 8;

    // watermark trigger counts, filled locations for receive
    localparam logic [LEVEL_W-1:0] TRIG_1_8 = 5'h02;
    localparam logic [LEVEL_W-1:0] TRIG_1_4 = 5'h04;
    localparam logic [LEVEL_W-1:0] TRIG_1_2 = 5'h08;
    localparam logic [LEVEL_W-1:0] TRIG_3_4 = 5'h0C;
    localparam logic [LEVEL_W-1:0] TRIG_7_8 = 5'h0E;
    localparam logic [LEVEL_W-1:0] FIFO_FULL_LVL = 5'h10;

    typedef enum logic [2:0] {
        WM_1_8 = 3'b000,
        WM_1_4 = 3'b001,
        WM_1_2 = 3'b010,
        WM_3_4 = 3'b011,
        WM_7_8 = 3'b100
    } ufc_wm_t;

    typedef struct packed {
        logic rx_single;
        logic rx_burst;
        logic tx_single;
        logic tx_burst;
    } ufc_dma_req_t;

    typedef struct packed {
        logic rx_clear;
        logic tx_clear;
    } ufc_dma_clr_t;

    typedef struct packed {
        logic request_to_send_out_n;
        logic terminal_ready_out_n;
        logic spare_out_one_n;
        logic spare_out_two_n;
    } ufc_modem_out_t;
endpackage : ufc_pkg

// ===== verilog/ufc_req_chan.sv
// one dma request line with sticky hold until the controller clears it or enable_i drops
// assumes condition, enable and clear all sit on the bus clock
`timescale 1ns/100ps
module ufc_req_chan (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic enable_i,
    input wire logic cond_i,
    input wire logic clear_i,
    output logic req_o
);
    logic req_q;

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            req_q <= 1'b0;
        end else if (!enable_i) begin
            req_q <= 1'b0;
        end else if (clear_i) begin
            // clear wins: a request may only rise after clear is removed
            req_q <= 1'b0;
        end else if (!req_q && cond_i) begin
            req_q <= 1'b1;
        end
    end

    assign req_o = req_q;
endmodule : ufc_req_chan

// ===== verilog/ufc_flow_dma.sv
// modem lines, hardware flow control and dma request logic of a uart
// assumes fifo levels, error interrupt and dma clears on clk_sys_i;
// modem input pins are asynchronous and are synchronised here
`timescale 1ns/100ps
module ufc_flow_dma #(
    parameter int DEPTH = ufc_pkg::FIFO_DEPTH,
    parameter int LVL_W = ufc_pkg::LEVEL_W
) (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // fifo state from the datapath
    input wire logic [LVL_W-1:0] rx_level_i,
    input wire logic [LVL_W-1:0] tx_level_i,
    input wire logic error_interrupt_i,
    // transmitter and receiver gating
    output logic tx_start_ok_o,
    output logic rx_accept_ok_o,
    // modem pins
    input wire logic clear_to_send_in_n_i,
    input wire logic set_ready_in_n_i,
    input wire logic carrier_detect_in_n_i,
    input wire logic ring_indicate_in_n_i,
    output ufc_pkg::ufc_modem_out_t modem_o,
    // dma handshake
    input wire ufc_pkg::ufc_dma_clr_t dma_clr_i,
    output ufc_pkg::ufc_dma_req_t dma_req_o
);
    localparam int NPIN = 4;

    logic [15:0] serial_control_reg_q;
    logic [5:0] fifo_level_select_reg_q;
    logic [2:0] serial_dma_control_reg_q;
    logic [1:0] flow_config_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [NPIN-1:0] pin_meta_q;
    logic [NPIN-1:0] pin_sync_q;
    ufc_pkg::ufc_modem_out_t modem_q;
    logic tx_start_ok_q;
    logic rx_accept_ok_q;
    ufc_pkg::ufc_dma_req_t req_w;

    logic uart_en;
    logic fifo_en;
    logic comm_role;
    logic rx_flow_en;
    logic tx_flow_en;
    logic cts_asserted;
    logic [LVL_W-1:0] rx_trig;
    logic [LVL_W-1:0] tx_trig_empty;
    logic [LVL_W-1:0] tx_empty;
    logic rx_below_wm;
    logic rx_dma_en;
    logic tx_dma_en;
    logic setup_ph;
    logic wr_acc;
    logic addr_ok;
    logic [31:0] rd_mux;

    // maps a watermark select to its fill count
    function automatic logic [LVL_W-1:0] trig_of(input logic [2:0] sel);
        logic [LVL_W-1:0] t;
        t = ufc_pkg::TRIG_1_2;
        case (sel)
            ufc_pkg::WM_1_8: t = ufc_pkg::TRIG_1_8;
            ufc_pkg::WM_1_4: t = ufc_pkg::TRIG_1_4;
            ufc_pkg::WM_1_2: t = ufc_pkg::TRIG_1_2;
            ufc_pkg::WM_3_4: t = ufc_pkg::TRIG_3_4;
            ufc_pkg::WM_7_8: t = ufc_pkg::TRIG_7_8;
            // reserved codes fall back to half full
            default: t = ufc_pkg::TRIG_1_2;
        endcase
        return t;
    endfunction : trig_of

    assign uart_en = serial_control_reg_q[ufc_pkg::CR_UART_EN];
    assign rx_flow_en = serial_control_reg_q[ufc_pkg::CR_RX_FLOW_EN];
    assign tx_flow_en = serial_control_reg_q[ufc_pkg::CR_TX_FLOW_EN];
    assign fifo_en = flow_config_q[ufc_pkg::CFG_FIFO_EN];
    assign comm_role = flow_config_q[ufc_pkg::CFG_COMM_ROLE];
    assign rx_dma_en = serial_dma_control_reg_q[ufc_pkg::DMA_RX_EN];
    assign tx_dma_en = serial_dma_control_reg_q[ufc_pkg::DMA_TX_EN];

    assign rx_trig = trig_of(
        fifo_level_select_reg_q[ufc_pkg::IFLS_RX_LSB +: ufc_pkg::IFLS_W]);
    // transmit empties are the mirror of the receive fill counts
    assign tx_trig_empty = ufc_pkg::FIFO_FULL_LVL - trig_of(
        fifo_level_select_reg_q[ufc_pkg::IFLS_TX_LSB +: ufc_pkg::IFLS_W]);
    assign tx_empty = ufc_pkg::FIFO_FULL_LVL - tx_level_i;
    assign rx_below_wm = rx_level_i < rx_trig;

    // pin 0 cts, 1 dsr, 2 dcd, 3 ri; low level means asserted
    assign cts_asserted = !pin_sync_q[0];

    // two-flop synchronisers for the asynchronous modem inputs
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            pin_meta_q <= '1;
            pin_sync_q <= '1;
        end else begin
            pin_meta_q <= {ring_indicate_in_n_i, carrier_detect_in_n_i,
                           set_ready_in_n_i, clear_to_send_in_n_i};
            pin_sync_q <= pin_meta_q;
        end
    end

    // apb decode
    assign setup_ph = psel_i && !penable_i;
    assign wr_acc = psel_i && penable_i && pready_q && pwrite_i;

    always_comb begin
        addr_ok = 1'b1;
        rd_mux = 32'h00000000;
        if (paddr_i == ufc_pkg::OFF_SERIAL_CTRL) begin
            rd_mux[15:0] = serial_control_reg_q;
        end else if (paddr_i == ufc_pkg::OFF_FIFO_LEVEL) begin
            rd_mux[5:0] = fifo_level_select_reg_q;
        end else if (paddr_i == ufc_pkg::OFF_DMA_CTRL) begin
            rd_mux[2:0] = serial_dma_control_reg_q;
        end else if (paddr_i == ufc_pkg::OFF_FLOW_STATUS) begin
            // read-only view of live pins and block state
            rd_mux[3:0] = ~pin_sync_q;
            rd_mux[4] = !modem_q.request_to_send_out_n;
            rd_mux[5] = tx_start_ok_q;
            rd_mux[6] = rx_accept_ok_q;
            rd_mux[7] = dma_req_o.rx_single;
            rd_mux[8] = dma_req_o.rx_burst;
            rd_mux[9] = dma_req_o.tx_single;
            rd_mux[10] = dma_req_o.tx_burst;
        end else if (paddr_i == ufc_pkg::OFF_FLOW_CONFIG) begin
            rd_mux[1:0] = flow_config_q;
        end else begin
            addr_ok = 1'b0;
        end
    end

    // zero-wait slave: answer prepared in the setup cycle
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else begin
            pready_q <= setup_ph;
            pslverr_q <= setup_ph && !addr_ok;
            if (setup_ph) begin
                prdata_q <= pwrite_i ? 32'h00000000 : rd_mux;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            serial_control_reg_q <= ufc_pkg::RST_SERIAL_CTRL;
        end else if (wr_acc && paddr_i == ufc_pkg::OFF_SERIAL_CTRL) begin
            serial_control_reg_q <= pwdata_i[15:0];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            fifo_level_select_reg_q <= ufc_pkg::RST_FIFO_LEVEL;
        end else if (wr_acc && paddr_i == ufc_pkg::OFF_FIFO_LEVEL) begin
            fifo_level_select_reg_q <= pwdata_i[5:0];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            serial_dma_control_reg_q <= ufc_pkg::RST_DMA_CTRL;
        end else if (wr_acc && paddr_i == ufc_pkg::OFF_DMA_CTRL) begin
            serial_dma_control_reg_q <= pwdata_i[2:0];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            flow_config_q <= ufc_pkg::RST_FLOW_CONFIG;
        end else if (wr_acc && paddr_i == ufc_pkg::OFF_FLOW_CONFIG) begin
            flow_config_q <= pwdata_i[1:0];
        end
    end

    // modem outputs; software bits are active high, pins active low
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            modem_q <= '1;
        end else begin
            if (rx_flow_en) begin
                // asserted below watermark, released at it
                modem_q.request_to_send_out_n <= !rx_below_wm;
            end else begin
                modem_q.request_to_send_out_n <=
                    !serial_control_reg_q[ufc_pkg::CR_REQ_SEND];
            end
            modem_q.terminal_ready_out_n <=
                !serial_control_reg_q[ufc_pkg::CR_TERM_READY];
            // spares only carry carrier detect and ring in the comm role
            modem_q.spare_out_one_n <= !(comm_role &&
                serial_control_reg_q[ufc_pkg::CR_SPARE_ONE]);
            modem_q.spare_out_two_n <= !(comm_role &&
                serial_control_reg_q[ufc_pkg::CR_SPARE_TWO]);
        end
    end

    // start permit is sampled by the shifter only between characters,
    // so a cts drop mid-character lets that character finish
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            tx_start_ok_q <= 1'b0;
            rx_accept_ok_q <= 1'b0;
        end else begin
            tx_start_ok_q <= uart_en && (tx_level_i != '0) &&
                (!tx_flow_en || cts_asserted);
            // peer is trusted to stop after the current character
            rx_accept_ok_q <= uart_en &&
                (rx_level_i < ufc_pkg::FIFO_FULL_LVL);
        end
    end

    // dma request conditions, all on the bus clock
    logic rx_en_eff;
    logic tx_en_eff;
    logic rx_single_cond;
    logic rx_burst_cond;
    logic tx_single_cond;
    logic tx_burst_cond;

    assign rx_en_eff = uart_en && rx_dma_en && !(error_interrupt_i &&
        serial_dma_control_reg_q[ufc_pkg::DMA_OFF_ERR]);
    assign tx_en_eff = uart_en && tx_dma_en;
    assign rx_single_cond = rx_level_i != '0;
    assign rx_burst_cond = fifo_en && (rx_level_i >= rx_trig);
    assign tx_single_cond = tx_level_i < ufc_pkg::FIFO_FULL_LVL;
    assign tx_burst_cond = fifo_en && (tx_empty >= tx_trig_empty);

    // four independent channels so single and burst may coexist
    ufc_req_chan u_rx_single (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .enable_i(rx_en_eff),
        .cond_i(rx_single_cond),
        .clear_i(dma_clr_i.rx_clear),
        .req_o(req_w.rx_single)
    );

    ufc_req_chan u_rx_burst (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .enable_i(rx_en_eff),
        .cond_i(rx_burst_cond),
        .clear_i(dma_clr_i.rx_clear),
        .req_o(req_w.rx_burst)
    );

    ufc_req_chan u_tx_single (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .enable_i(tx_en_eff),
        .cond_i(tx_single_cond),
        .clear_i(dma_clr_i.tx_clear),
        .req_o(req_w.tx_single)
    );

    ufc_req_chan u_tx_burst (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .enable_i(tx_en_eff),
        .cond_i(tx_burst_cond),
        .clear_i(dma_clr_i.tx_clear),
        .req_o(req_w.tx_burst)
    );

    assign dma_req_o = req_w;
    assign modem_o = modem_q;
    assign tx_start_ok_o = tx_start_ok_q;
    assign rx_accept_ok_o = rx_accept_ok_q;
    assign prdata_o = prdata_q;
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;
endmodule : ufc_flow_dma

// ===== tb/ufc_peer_model.sv
// dma controller and modem peer stand-in for the bench
// assumes requests are levels on the bus clock
`timescale 1ns/100ps
module ufc_peer_model (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire ufc_pkg::ufc_dma_req_t dma_req_i,
    input wire logic auto_i,
    input wire logic [3:0] gap_i,
    input wire logic clr_now_i,
    input wire logic cts_on_i,
    output ufc_pkg::ufc_dma_clr_t dma_clr_o,
    output logic cts_n_o,
    output logic dsr_n_o,
    output logic dcd_n_o,
    output logic ri_n_o
);
    logic [3:0] wait_q;
    logic hit_q;
    // slow answer: clears only after gap_i + 1 cycles of pending request
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i || !auto_i || dma_req_i == '0) begin
            wait_q <= 4'h0;
            hit_q <= 1'b0;
        end else begin
            wait_q <= hit_q ? 4'h0 : wait_q + 4'h1;
            hit_q <= wait_q == gap_i;
        end
    end
    assign dma_clr_o.rx_clear = clr_now_i | hit_q;
    assign dma_clr_o.tx_clear = clr_now_i | hit_q;
    // no serial data here: the peer is taken to stop after a character
    // once rts is released
    assign cts_n_o = !cts_on_i;
    // unused status pins idle deasserted, as with a pull-up
    assign dsr_n_o = 1'b1;
    assign dcd_n_o = 1'b1;
    assign ri_n_o = 1'b1;
endmodule : ufc_peer_model

// ===== tb/ufc_flow_dma_asserts.sv
// port assertions for the flow control and dma block
// assumes register writes land at the apb access edge
`timescale 1ns/100ps
module ufc_flow_dma_asserts #(
    parameter int DEPTH = 16,
    parameter int LVL_W = 5
) (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic pready_o,
    input wire logic [LVL_W-1:0] rx_level_i,
    input wire logic [LVL_W-1:0] tx_level_i,
    input wire logic error_interrupt_i,
    input wire ufc_pkg::ufc_modem_out_t modem_o,
    input wire ufc_pkg::ufc_dma_clr_t dma_clr_i,
    input wire ufc_pkg::ufc_dma_req_t dma_req_o
);
    logic [15:0] cr_q;
    logic [2:0] dm_q;
    logic [5:0] lv_q;
    logic cf_q;
    logic rx_en, tx_en, rx_hi, tx_lo;
    function automatic int trg(input logic [2:0] c);
        return c == 0 ? 2 : c == 1 ? 4 : c == 3 ? 12 : c == 4 ? 14 : 8;
    endfunction : trg
    // shadow copy, since the checker sees only the ports
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            cr_q <= ufc_pkg::RST_SERIAL_CTRL;
            dm_q <= ufc_pkg::RST_DMA_CTRL;
            lv_q <= ufc_pkg::RST_FIFO_LEVEL;
            cf_q <= ufc_pkg::RST_FLOW_CONFIG[0];
        end else if (psel_i && penable_i && pready_o && pwrite_i) begin
            if (paddr_i == ufc_pkg::OFF_SERIAL_CTRL) cr_q <= pwdata_i[15:0];
            if (paddr_i == ufc_pkg::OFF_DMA_CTRL) dm_q <= pwdata_i[2:0];
            if (paddr_i == ufc_pkg::OFF_FIFO_LEVEL) lv_q <= pwdata_i[5:0];
            if (paddr_i == ufc_pkg::OFF_FLOW_CONFIG) cf_q <= pwdata_i[0];
        end
    end
    assign rx_en = cr_q[0] && dm_q[0] && !(dm_q[2] && error_interrupt_i);
    assign tx_en = cr_q[0] && dm_q[1];
    assign rx_hi = rx_level_i >= trg(lv_q[5:3]);
    assign tx_lo = tx_level_i <= trg(lv_q[2:0]);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    rx_clear_wins_a: assert property (dma_clr_i.rx_clear |=>
        !dma_req_o.rx_single && !dma_req_o.rx_burst) else $error("rx clr");
    tx_clear_wins_a: assert property (dma_clr_i.tx_clear |=>
        !dma_req_o.tx_single && !dma_req_o.tx_burst) else $error("tx clr");
    rx_gate_off_a: assert property (!rx_en |=>
        !dma_req_o.rx_single && !dma_req_o.rx_burst) else $error("rx off");
    tx_gate_off_a: assert property (!tx_en |=>
        !dma_req_o.tx_single && !dma_req_o.tx_burst) else $error("tx off");
    rx_single_set_a: assert property (rx_en && rx_level_i != 0 &&
        !dma_clr_i.rx_clear |=> dma_req_o.rx_single) else $error("rx s");
    rx_burst_set_a: assert property (rx_en && cf_q && rx_hi &&
        !dma_clr_i.rx_clear |=> dma_req_o.rx_burst) else $error("rx b");
    tx_burst_set_a: assert property (tx_en && cf_q && tx_lo &&
        !dma_clr_i.tx_clear |=> dma_req_o.tx_burst) else $error("tx b");
    req_hold_a: assert property (dma_req_o.rx_single && rx_en &&
        !dma_clr_i.rx_clear |=> dma_req_o.rx_single) else $error("hold");
    fifo_off_a: assert property (!cf_q && !dma_req_o.rx_burst |=>
        !dma_req_o.rx_burst) else $error("burst with fifo off");
    rts_flow_a: assert property (cr_q[14] && cf_q |=>
        modem_o.request_to_send_out_n == $past(rx_hi)) else $error("rts");
    cover property (dma_req_o.rx_burst && dma_req_o.rx_single);
    cover property (dma_clr_i.tx_clear ##1 !dma_req_o.tx_burst);
    cover property (cr_q[14] && modem_o.request_to_send_out_n);
endmodule : ufc_flow_dma_asserts
bind ufc_flow_dma ufc_flow_dma_asserts #(.DEPTH(DEPTH), .LVL_W(LVL_W)) u_chk (
    .clk_sys_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .pready_o, .rx_level_i, .tx_level_i, .error_interrupt_i,
    .modem_o, .dma_clr_i, .dma_req_o);

// ===== tb/ufc_flow_dma_tb_top.sv
// self-checking bench for the uart flow control and dma block
// assumes the peer model answers dma requests and drives modem pins
`timescale 1ns/100ps
module ufc_flow_dma_tb_top;
    logic clk_sys_i = 1'b0;
    logic nrst_i = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [4:0] rx_lvl = 5'h00;
    logic [4:0] tx_lvl = 5'h00;
    logic err = 1'b0;
    logic auto_on = 1'b0;
    logic clr_now = 1'b0;
    logic cts_on = 1'b0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, tx_ok, rx_ok, cts_n, dsr_n, dcd_n, ri_n;
    ufc_pkg::ufc_modem_out_t modem;
    ufc_pkg::ufc_dma_clr_t clr;
    ufc_pkg::ufc_dma_req_t req;
    logic [31:0] seed = 32'h0001_795A;
    int n_fail = 0;
    int checks = 0;
    int cr, dm, lv, cf;
    ufc_flow_dma u_dut (
        .clk_sys_i, .nrst_i, .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .rx_level_i(rx_lvl), .tx_level_i(tx_lvl), .error_interrupt_i(err),
        .tx_start_ok_o(tx_ok), .rx_accept_ok_o(rx_ok),
        .clear_to_send_in_n_i(cts_n), .set_ready_in_n_i(dsr_n),
        .carrier_detect_in_n_i(dcd_n), .ring_indicate_in_n_i(ri_n),
        .modem_o(modem), .dma_clr_i(clr), .dma_req_o(req));
    ufc_peer_model u_peer (
        .clk_sys_i, .nrst_i, .dma_req_i(req), .auto_i(auto_on),
        .gap_i(4'h4), .clr_now_i(clr_now), .cts_on_i(cts_on),
        .dma_clr_o(clr), .cts_n_o(cts_n), .dsr_n_o(dsr_n),
        .dcd_n_o(dcd_n), .ri_n_o(ri_n));
    always #10 clk_sys_i = ~clk_sys_i;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic int trg(input int c);
        return c == 0 ? 2 : c == 1 ? 4 : c == 3 ? 12 : c == 4 ? 14 : 8;
    endfunction : trg
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input int d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= 32'(d);
        @(posedge clk_sys_i);
        penable <= 1'b1;
        @(posedge clk_sys_i);
        // only the watchdog ends a wait for the answer
        while (pready !== 1'b1) begin
            @(posedge clk_sys_i);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys_i);
    endtask : apb
    task automatic cfg();
        apb(1'b1, ufc_pkg::OFF_SERIAL_CTRL, cr);
        apb(1'b1, ufc_pkg::OFF_DMA_CTRL, dm);
        apb(1'b1, ufc_pkg::OFF_FIFO_LEVEL, lv);
        apb(1'b1, ufc_pkg::OFF_FLOW_CONFIG, cf);
    endtask : cfg
    // clears first, so sticky requests show the new levels only
    task automatic step(input int rx, input int tx);
        logic rxe, txe, r;
        logic [3:0] e;
        rxe = cr[0] && dm[0] && !(dm[2] && err);
        txe = cr[0] && dm[1];
        e = {rxe && rx > 0, rxe && cf[0] && rx >= trg(lv[5:3]),
            txe && tx < 16, txe && cf[0] && tx <= trg(lv[2:0])};
        r = cr[14] ? rx >= trg(lv[5:3]) : !cr[11];
        rx_lvl <= 5'(rx);
        tx_lvl <= 5'(tx);
        clr_now <= 1'b1;
        @(posedge clk_sys_i);
        clr_now <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        chk(32'(req), 32'(e));
        if (cr[0] && cf[0]) chk(32'(modem[3]), 32'(r));
    endtask : step
    task automatic close_out();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : close_out
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        n_fail++;
        close_out();
    end
    initial begin
        repeat (3) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        apb(1'b0, ufc_pkg::OFF_SERIAL_CTRL, 0);
        chk(rd, 32'(ufc_pkg::RST_SERIAL_CTRL));
        apb(1'b0, ufc_pkg::OFF_FIFO_LEVEL, 0);
        chk(rd, 32'(ufc_pkg::RST_FIFO_LEVEL));
        apb(1'b0, 12'h00C, 0);
        chk({rd[30:0], er}, 32'h1);
        chk(32'(modem), 32'h0000_000F);
        $display("test reset done");
        cr = 32'h4301;
        dm = 3;
        cf = 1;
        for (int k = 0; k < 5; k++) begin
            lv = k * 9;
            cfg();
            step(trg(k), trg(k));
            step(trg(k) - 1, trg(k) + 1);
        end
        $display("test watermarks done");
        for (int i = 0; i < 40; i++) begin
            seed = lfsr(seed);
            cr = int'(seed & 32'h0000_C800) | 32'h300 | (seed[2:0] != 0);
            dm = seed[18:16];
            lv = seed[25:20];
            cf = seed[26] | seed[27];
            err <= seed[28];
            cfg();
            step(seed[12:8] % 17, seed[7:3] % 17);
        end
        $display("test random done");
        cr = 32'h0301;
        lv = 18;
        cf = 1;
        dm = 3;
        err <= 1'b0;
        cfg();
        step(1, 16);
        rx_lvl <= 5'h00;
        repeat (4) @(posedge clk_sys_i);
        chk(32'(req.rx_single), 32'h1);
        auto_on <= 1'b1;
        repeat (12) @(posedge clk_sys_i);
        chk(32'(req.rx_single), 32'h0);
        auto_on <= 1'b0;
        cr = 32'h8301;
        cfg();
        tx_lvl <= 5'h03;
        repeat (6) @(posedge clk_sys_i);
        chk(32'(tx_ok), 32'h0);
        cts_on <= 1'b1;
        repeat (6) @(posedge clk_sys_i);
        chk(32'(tx_ok), 32'h1);
        cr = 32'h0301;
        cfg();
        cts_on <= 1'b0;
        repeat (6) @(posedge clk_sys_i);
        chk(32'(tx_ok), 32'h1);
        rx_lvl <= 5'h10;
        repeat (3) @(posedge clk_sys_i);
        chk(32'(rx_ok), 32'h0);
        // communication role: spares follow their control bits
        cr = 32'h3301;
        cf = 3;
        cfg();
        repeat (2) @(posedge clk_sys_i);
        chk(32'(modem), 32'h0000_000C);
        // status: tx start permit and all four requests pending
        apb(1'b0, ufc_pkg::OFF_FLOW_STATUS, 0);
        chk(rd, 32'h0000_07A0);
        $display("test modem done");
        close_out();
    end
endmodule : ufc_flow_dma_tb_top
